// ===== inc/phy_ctrl_defs.svh
// constants shared by the management link ends and the physical layer control block
`ifndef PHY_CTRL_DEFS_SVH
`define PHY_CTRL_DEFS_SVH

// widths
`define ADDR_W         5
`define DATA_W         16
`define FRAME_W        27

// device register indices on the management link
`define BMC_REG_IDX    5'h00
`define TB_REG_IDX     5'h18
`define PC_REG_IDX     5'h19

// field positions
`define ISO_BIT        10
`define HBD_BIT        7
`define HUB_BIT        9
`define LEDM_HI        8
`define LEDM_LO        7
`define DUPM_BIT       6
`define FIBER_BIT      5
`define ADDR_HI        4

// activity led modes and reset values
`define LED_NORMAL     2'h0
`define RECEIVE_ACTIVITY_LED_CIM     2'h1
`define LED_ALL_CIM    2'h2
`define LED_ALL_INT    2'h3
`define ADDR_ZERO      5'h00
`define DATA_ZERO      16'h0000

// frame bit positions, counted from the first frame cycle
`define HDR_LAST       5'h0A
`define TURN_CYC       5'h0B
`define RD_FIRST       5'h0C
`define WR_LAST        5'h1A
`define RD_LAST        5'h1B
`define CNT_MAX        5'h1F
`define CNT_ONE        5'h01

// controller register offsets and bits
`define CR_TARGET      5'h00
`define CR_WDATA       5'h04
`define CR_COMMAND     5'h08
`define CR_STATUS      5'h0C
`define CR_RDATA       5'h10
`define CMD_START_BIT  0
`define CMD_READ_BIT   1
`define TGT_REG_LO     8
`define TGT_REG_HI     12
`define BUS_ZERO       32'h0000_0000

`endif

// ===== inc/phy_ctrl_pkg.sv
// types shared by the management link ends
package phy_ctrl_pkg;
    typedef enum logic [1:0] {H_IDLE, H_SEND, H_RECV, H_GAP} host_state_e;
    typedef logic [4:0] count_t;
endpackage : phy_ctrl_pkg

// ===== inc/mgmt_link_if.sv
// serial management link between controller and physical layer device
`timescale 1ns/1ps
interface mgmt_link_if;
    logic frame;
    logic host_o;
    logic host_oe;
    logic dev_o;
    logic dev_oe;
    logic mdio;

    // shared data line, pulled high when idle
    assign mdio = host_oe ? host_o : (dev_oe ? dev_o : 1'b1);

    modport host (output frame, output host_o, output host_oe, input mdio);
    modport device (input frame, output dev_o, output dev_oe, input mdio);
endinterface : mgmt_link_if

// ===== logic/mgmt_controller.sv
// station management controller driving the serial management link
`timescale 1ns/1ps
`include "phy_ctrl_defs.svh"
module mgmt_controller
    import phy_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    // software port
    input  wire logic [4:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rdata_out,
    // management link
    mgmt_link_if.host        link
);
    host_state_e              state_r, state_nxt;
    count_t                   cnt_r, cnt_nxt;
    logic [2*`ADDR_W-1:0]     target_r, target_nxt;
    logic [`DATA_W-1:0]       wdata_r, wdata_nxt;
    logic [`DATA_W-1:0]       rdata_r, rdata_nxt;
    logic [`FRAME_W-1:0]      sr_r, sr_nxt;
    logic                     rd_op_r, rd_op_nxt;
    logic                     done_r, done_nxt;
    logic                     frame_r, frame_nxt;
    logic                     host_o_r, host_o_nxt;
    logic                     host_oe_r, host_oe_nxt;
    logic [31:0]              bus_r, bus_nxt;
    logic                     start;

    assign link.frame   = frame_r;
    assign link.host_o  = host_o_r;
    assign link.host_oe = host_oe_r;
    assign rdata_out    = bus_r;
    assign start = wr_in && (addr_in == `CR_COMMAND) && wdata_in[`CMD_START_BIT];

    always_comb
    begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r;
        target_nxt  = target_r;
        wdata_nxt   = wdata_r;
        rdata_nxt   = rdata_r;
        sr_nxt      = sr_r;
        rd_op_nxt   = rd_op_r;
        done_nxt    = done_r;
        frame_nxt   = frame_r;
        host_o_nxt  = host_o_r;
        host_oe_nxt = host_oe_r;
        bus_nxt     = `BUS_ZERO;
        if (wr_in && addr_in == `CR_TARGET)
        begin
            target_nxt = {wdata_in[`TGT_REG_HI:`TGT_REG_LO], wdata_in[`ADDR_HI:0]};
        end
        if (wr_in && addr_in == `CR_WDATA)
        begin
            wdata_nxt = wdata_in[`DATA_W-1:0];
        end
        case (state_r)
            H_IDLE:
            begin
                if (start)
                begin
                    host_o_nxt  = wdata_in[`CMD_READ_BIT];
                    // station address goes out ahead of the register index
                    sr_nxt      = {target_r[`ADDR_W-1:0], target_r[2*`ADDR_W-1:`ADDR_W],
                                   wdata_r, 1'b0};
                    rd_op_nxt   = wdata_in[`CMD_READ_BIT];
                    frame_nxt   = 1'b1;
                    host_oe_nxt = 1'b1;
                    cnt_nxt     = '0;
                    done_nxt    = 1'b0;
                    state_nxt   = H_SEND;
                end
            end
            H_SEND:
            begin
                cnt_nxt    = cnt_r + `CNT_ONE;
                host_o_nxt = sr_r[`FRAME_W-1];
                sr_nxt     = {sr_r[`FRAME_W-2:0], 1'b0};
                if (rd_op_r && cnt_r == `HDR_LAST)
                begin
                    host_oe_nxt = 1'b0;
                    state_nxt   = H_RECV;
                end
                else if (!rd_op_r && cnt_r == `WR_LAST)
                begin
                    frame_nxt   = 1'b0;
                    host_oe_nxt = 1'b0;
                    done_nxt    = 1'b1;
                    state_nxt   = H_GAP;
                end
            end
            H_RECV:
            begin
                cnt_nxt = cnt_r + `CNT_ONE;
                if (cnt_r >= `RD_FIRST)
                begin
                    rdata_nxt = {rdata_r[`DATA_W-2:0], link.mdio};
                end
                if (cnt_r == `RD_LAST)
                begin
                    frame_nxt = 1'b0;
                    done_nxt  = 1'b1;
                    state_nxt = H_GAP;
                end
            end
            H_GAP:
            begin
                state_nxt = H_IDLE;
            end
            default:
            begin
                state_nxt = H_IDLE;
            end
        endcase
        if (rd_in)
        begin
            case (addr_in)
                `CR_TARGET:  bus_nxt = {19'h0, target_r[9:5], 3'h0, target_r[4:0]};
                `CR_WDATA:   bus_nxt = {16'h0, wdata_r};
                `CR_STATUS:  bus_nxt = {30'h0, done_r, state_r != H_IDLE};
                `CR_RDATA:   bus_nxt = {16'h0, rdata_r};
                default:     bus_nxt = `BUS_ZERO;
            endcase
        end
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_r   <= H_IDLE;
            cnt_r     <= '0;
            target_r  <= '0;
            wdata_r   <= `DATA_ZERO;
            rdata_r   <= `DATA_ZERO;
            sr_r      <= '0;
            rd_op_r   <= 1'b0;
            done_r    <= 1'b0;
            frame_r   <= 1'b0;
            host_o_r  <= 1'b0;
            host_oe_r <= 1'b0;
            bus_r     <= `BUS_ZERO;
        end
        else if (ce_in)
        begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            target_r  <= target_nxt;
            wdata_r   <= wdata_nxt;
            rdata_r   <= rdata_nxt;
            sr_r      <= sr_nxt;
            rd_op_r   <= rd_op_nxt;
            done_r    <= done_nxt;
            frame_r   <= frame_nxt;
            host_o_r  <= host_o_nxt;
            host_oe_r <= host_oe_nxt;
            bus_r     <= bus_nxt;
        end
    end
endmodule : mgmt_controller

// ===== logic/phy_ctrl_device.sv
// physical layer control register, mode logic and led steering of the device end
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "phy_ctrl_defs.svh"
module phy_ctrl_device
    import phy_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    // straps
    input  wire logic        hub_strap_in,
    input  wire logic        fiber_strap_in,
    input  wire logic [4:0]  station_address_straps_in,
    // line status
    input  wire logic        rx_active_in,
    input  wire logic        tx_active_in,
    input  wire logic        full_duplex_in,
    input  wire logic        speed_100_in,
    input  wire logic        polarity_reversed_in,
    input  wire logic        carrier_integrity_monitor_in,
    input  wire logic        interrupt_in,
    // external settings
    input  wire logic        far_end_fault_enable_in,
    input  wire logic        scrambler_bypass_in,
    // indications and controls
    output logic             carrier_sense_out,
    output logic             receive_activity_led_out,
    output logic             transmit_activity_led_out,
    output logic             duplex_polarity_led_out,
    output logic             cim_enable_out,
    output logic             heartbeat_disable_out,
    output logic             far_end_fault_enable_out,
    output logic             scrambler_bypass_out,
    output logic             isolate_out,
    // management link
    mgmt_link_if.device      link
);
    // register state
    logic                    loaded_r, loaded_nxt;
    logic                    hub_r, hub_nxt;
    logic [1:0]              ledm_r, ledm_nxt;
    logic                    dupm_r, dupm_nxt;
    logic                    fiber_r, fiber_nxt;
    logic [`ADDR_W-1:0]      addr_r, addr_nxt;
    logic                    iso_r, iso_nxt;
    logic                    hbd_r, hbd_nxt;
    // link state
    count_t                  cnt_r, cnt_nxt;
    logic [`DATA_W-1:0]      shift_r, shift_nxt;
    logic [`DATA_W-1:0]      dout_r, dout_nxt;
    logic                    match_r, match_nxt;
    logic                    read_r, read_nxt;
    logic [`ADDR_W-1:0]      ridx_r, ridx_nxt;
    logic                    dev_o_r, dev_o_nxt;
    logic                    dev_oe_r, dev_oe_nxt;
    logic [`DATA_W-1:0]      rd_value;
    logic [`DATA_W-1:0]      wd;
    // output state
    logic [8:0]              out_r, out_nxt;

    assign link.dev_o  = dev_o_r;
    assign link.dev_oe = dev_oe_r;
    assign wd = {shift_r[`DATA_W-2:0], link.mdio};

    // register contents as seen on the link
    function automatic logic [`DATA_W-1:0] reg_read(input logic [`ADDR_W-1:0] idx);
        logic [`DATA_W-1:0] v;
        v = `DATA_ZERO;
        case (idx)
            `BMC_REG_IDX: v[`ISO_BIT] = iso_r;
            `TB_REG_IDX:  v[`HBD_BIT] = hbd_r | full_duplex_in | hub_r;
            `PC_REG_IDX:  v[`HUB_BIT:0] = {hub_r, ledm_r, dupm_r, fiber_r, addr_r};
            default:      v = `DATA_ZERO;
        endcase
        return v;
    endfunction : reg_read

    assign rd_value = reg_read(ridx_r);

    always_comb
    begin
        loaded_nxt = loaded_r;
        hub_nxt    = hub_r;
        ledm_nxt   = ledm_r;
        dupm_nxt   = dupm_r;
        fiber_nxt  = fiber_r;
        addr_nxt   = addr_r;
        iso_nxt    = iso_r;
        hbd_nxt    = hbd_r;
        cnt_nxt    = cnt_r;
        shift_nxt  = shift_r;
        dout_nxt   = dout_r;
        match_nxt  = match_r;
        read_nxt   = read_r;
        ridx_nxt   = ridx_r;
        dev_o_nxt  = dev_o_r;
        dev_oe_nxt = dev_oe_r;
        if (!loaded_r)
        begin
            hub_nxt    = hub_strap_in;
            fiber_nxt  = fiber_strap_in;
            addr_nxt   = station_address_straps_in;
            iso_nxt    = (station_address_straps_in == `ADDR_ZERO);
            loaded_nxt = 1'b1;
        end
        if (!link.frame)
        begin
            cnt_nxt    = '0;
            dev_oe_nxt = 1'b0;
            match_nxt  = 1'b0;
        end
        else
        begin
            if (cnt_r != `CNT_MAX)
            begin
                cnt_nxt = cnt_r + `CNT_ONE;
            end
            shift_nxt = wd;
            if (cnt_r == `HDR_LAST)
            begin
                match_nxt = loaded_r && (shift_r[8:4] == addr_r);
                read_nxt  = shift_r[9];
                ridx_nxt  = {shift_r[3:0], link.mdio};
            end
            else if (cnt_r == `TURN_CYC && read_r && match_r)
            begin
                dev_o_nxt  = rd_value[`DATA_W-1];
                dout_nxt   = {rd_value[`DATA_W-2:0], 1'b0};
                dev_oe_nxt = 1'b1;
            end
            else if (cnt_r == `RD_LAST)
            begin
                dev_oe_nxt = 1'b0;
            end
            else if (dev_oe_r)
            begin
                dev_o_nxt = dout_r[`DATA_W-1];
                dout_nxt  = {dout_r[`DATA_W-2:0], 1'b0};
            end
            if (cnt_r == `WR_LAST && !read_r && match_r)
            begin
                case (ridx_r)
                    `BMC_REG_IDX: iso_nxt = wd[`ISO_BIT];
                    `TB_REG_IDX:  hbd_nxt = wd[`HBD_BIT];
                    `PC_REG_IDX:
                    begin
                        hub_nxt   = wd[`HUB_BIT];
                        ledm_nxt  = wd[`LEDM_HI:`LEDM_LO];
                        dupm_nxt  = wd[`DUPM_BIT];
                        fiber_nxt = wd[`FIBER_BIT];
                        addr_nxt  = wd[`ADDR_HI:0];
                    end
                    default:
                    begin
                        hbd_nxt = hbd_r;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            loaded_r <= 1'b0;
            hub_r    <= 1'b0;
            ledm_r   <= `LED_NORMAL;
            dupm_r   <= 1'b0;
            fiber_r  <= 1'b0;
            addr_r   <= `ADDR_ZERO;
            iso_r    <= 1'b0;
            hbd_r    <= 1'b0;
            cnt_r    <= '0;
            shift_r  <= `DATA_ZERO;
            dout_r   <= `DATA_ZERO;
            match_r  <= 1'b0;
            read_r   <= 1'b0;
            ridx_r   <= `ADDR_ZERO;
            dev_o_r  <= 1'b0;
            dev_oe_r <= 1'b0;
        end
        else if (ce_in)
        begin
            loaded_r <= loaded_nxt;
            hub_r    <= hub_nxt;
            ledm_r   <= ledm_nxt;
            dupm_r   <= dupm_nxt;
            fiber_r  <= fiber_nxt;
            addr_r   <= addr_nxt;
            iso_r    <= iso_nxt;
            hbd_r    <= hbd_nxt;
            cnt_r    <= cnt_nxt;
            shift_r  <= shift_nxt;
            dout_r   <= dout_nxt;
            match_r  <= match_nxt;
            read_r   <= read_nxt;
            ridx_r   <= ridx_nxt;
            dev_o_r  <= dev_o_nxt;
            dev_oe_r <= dev_oe_nxt;
        end
    end

    always_comb
    begin
        out_nxt = '0;
        // node half duplex: rx or tx
        out_nxt[0] = rx_active_in | (tx_active_in & ~hub_r & ~full_duplex_in);
        case (ledm_r)
            `RECEIVE_ACTIVITY_LED_CIM:  out_nxt[2:1] = {carrier_integrity_monitor_in, rx_active_in};
            `LED_ALL_CIM: out_nxt[2:1] = {carrier_integrity_monitor_in,
                                          rx_active_in | tx_active_in};
            `LED_ALL_INT: out_nxt[2:1] = {interrupt_in, rx_active_in | tx_active_in};
            default:      out_nxt[2:1] = {tx_active_in, rx_active_in};
        endcase
        out_nxt[3] = (dupm_r && !speed_100_in) ? polarity_reversed_in : full_duplex_in;
        out_nxt[4] = ~(hub_r & speed_100_in);
        out_nxt[5] = hbd_r | hub_r | full_duplex_in;
        out_nxt[6] = fiber_r | far_end_fault_enable_in;
        out_nxt[7] = fiber_r | scrambler_bypass_in;
        out_nxt[8] = iso_r;
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            out_r <= '0;
        end
        else if (ce_in)
        begin
            out_r <= out_nxt;
        end
    end

    assign carrier_sense_out         = out_r[0];
    assign receive_activity_led_out  = out_r[1];
    assign transmit_activity_led_out = out_r[2];
    assign duplex_polarity_led_out   = out_r[3];
    assign cim_enable_out            = out_r[4];
    assign heartbeat_disable_out     = out_r[5];
    assign far_end_fault_enable_out  = out_r[6];
    assign scrambler_bypass_out      = out_r[7];
    assign isolate_out               = out_r[8];
endmodule : phy_ctrl_device

// ===== dv/phy_ctrl_checker.sv
// concurrent checks on the management link and device indications
`timescale 1ns/1ps
module phy_ctrl_checker
(
    // clock and reset
    input  wire logic clock_in,
    input  wire logic rst_in,
    // link
    input  wire logic frame,
    input  wire logic host_oe,
    input  wire logic dev_oe,
    // device inputs
    input  wire logic rx_active_in,
    input  wire logic tx_active_in,
    input  wire logic full_duplex_in,
    input  wire logic speed_100_in,
    input  wire logic far_end_fault_enable_in,
    // device outputs
    input  wire logic carrier_sense_out,
    input  wire logic cim_enable_out,
    input  wire logic heartbeat_disable_out,
    input  wire logic far_end_fault_enable_out,
    input  wire logic scrambler_bypass_out,
    input  wire logic duplex_polarity_led_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);

    logic [1:0] up_r;
    logic [1:0] up_nxt;
    logic [4:0] fcnt_r;
    logic [4:0] fcnt_nxt;
    logic       up;

    // settle count after reset and frame length count
    always_comb
    begin
        up_nxt   = (up_r == 2'h3) ? up_r : up_r + 2'h1;
        fcnt_nxt = frame ? ((fcnt_r == 5'h1F) ? fcnt_r : fcnt_r + 5'h01) : 5'h00;
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            up_r   <= 2'h0;
            fcnt_r <= 5'h00;
        end
        else
        begin
            up_r   <= up_nxt;
            fcnt_r <= fcnt_nxt;
        end
    end

    assign up = (up_r == 2'h3);

    a_cs_on_rx: assert property (
        up && $past(rx_active_in) |-> carrier_sense_out) else $error("carrier sense missing");
    a_cs_idle: assert property (
        up && !$past(rx_active_in) && !$past(tx_active_in) |-> !carrier_sense_out)
        else $error("carrier sense without activity");
    a_cim_slow: assert property (
        up && !$past(speed_100_in) |-> cim_enable_out) else $error("monitor off at 10 Mb/s");
    a_hub_hb: assert property (
        up && !cim_enable_out |-> heartbeat_disable_out) else $error("heartbeat not forced");
    a_hb_duplex: assert property (
        up && $past(full_duplex_in) |-> heartbeat_disable_out) else $error("heartbeat on in duplex");
    a_fault_pass: assert property (
        up && $past(far_end_fault_enable_in) |-> far_end_fault_enable_out)
        else $error("fault enable lost");
    a_fiber_pair: assert property (
        up && far_end_fault_enable_out && !$past(far_end_fault_enable_in) |-> scrambler_bypass_out)
        else $error("fiber controls not paired");
    a_dup_fast: assert property (
        up && $past(speed_100_in) |-> duplex_polarity_led_out == $past(full_duplex_in))
        else $error("duplex led wrong at 100 Mb/s");
    a_link_clash: assert property (
        !(host_oe && dev_oe)) else $error("both ends drive the data line");
    a_frame_len: assert property (
        frame |-> fcnt_r <= 5'h1B) else $error("frame too long");
    a_idle_quiet: assert property (
        !frame |-> !dev_oe && !host_oe) else $error("data line driven outside frame");
endmodule : phy_ctrl_checker

// ===== dv/tb.sv
// testbench for the management controller and physical layer control device
`timescale 1ns/1ps
`include "phy_ctrl_defs.svh"
module tb;
    logic        clock_in = 1'b0;
    logic        rst_in   = 1'b1;
    logic [4:0]  addr     = 5'h00;
    logic [31:0] wdata    = 32'h0000_0000;
    logic        wr       = 1'b0;
    logic        rd       = 1'b0;
    logic [31:0] rdata;
    logic        hub_s    = 1'b0;
    logic        fib_s    = 1'b0;
    logic [4:0]  sta_s    = 5'h00;
    logic        rx = 1'b0, tx = 1'b0, fd = 1'b0, spd = 1'b0;
    logic        pol = 1'b0, carrier_integrity_monitor = 1'b0, intr = 1'b0, fefi = 1'b0, bps = 1'b0;
    logic        cs, rxl, txl, dupl, cime, hbd, fefo, bpso, iso;
    logic [4:0]  st = 5'h00;
    logic [27:0] fsh = 28'h0;
    logic [31:0] s;
    int          error_cnt = 0;
    int          check_count = 0;

    mgmt_link_if link();

    mgmt_controller mgmt_controller_inst (.clock_in(clock_in), .rst_in(rst_in), .ce_in(1'b1),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .link(link.host));

    phy_ctrl_device phy_ctrl_device_inst (.clock_in(clock_in), .rst_in(rst_in), .ce_in(1'b1),
        .hub_strap_in(hub_s), .fiber_strap_in(fib_s), .station_address_straps_in(sta_s),
        .rx_active_in(rx), .tx_active_in(tx), .full_duplex_in(fd), .speed_100_in(spd),
        .polarity_reversed_in(pol), .carrier_integrity_monitor_in(carrier_integrity_monitor), .interrupt_in(intr),
        .far_end_fault_enable_in(fefi), .scrambler_bypass_in(bps), .carrier_sense_out(cs),
        .receive_activity_led_out(rxl), .transmit_activity_led_out(txl),
        .duplex_polarity_led_out(dupl), .cim_enable_out(cime), .heartbeat_disable_out(hbd),
        .far_end_fault_enable_out(fefo), .scrambler_bypass_out(bpso), .isolate_out(iso),
        .link(link.device));

    phy_ctrl_checker phy_ctrl_checker_inst (.clock_in(clock_in), .rst_in(rst_in),
        .frame(link.frame), .host_oe(link.host_oe), .dev_oe(link.dev_oe),
        .rx_active_in(rx), .tx_active_in(tx), .full_duplex_in(fd), .speed_100_in(spd),
        .far_end_fault_enable_in(fefi), .carrier_sense_out(cs), .cim_enable_out(cime),
        .heartbeat_disable_out(hbd), .far_end_fault_enable_out(fefo),
        .scrambler_bypass_out(bpso), .duplex_polarity_led_out(dupl));

    always #50 clock_in = ~clock_in;

    // bits seen on the data line during frames
    always @(posedge clock_in)
        if (link.frame)
            fsh <= {fsh[26:0], link.mdio};

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task end_sim;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    task bus_wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clock_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock_in);
        wr <= 1'b0;
    endtask : bus_wr

    task bus_rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge clock_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock_in);
        rd <= 1'b0;
        @(negedge clock_in);
        d = rdata;
    endtask : bus_rd

    task mgmt(input logic rdop, input logic [4:0] ridx, input logic [15:0] d,
              output logic [15:0] q);
        logic [31:0] r;
        int          n;
        bus_wr(`CR_TARGET, {19'h0, ridx, 3'h0, st});
        bus_wr(`CR_WDATA, {16'h0, d});
        bus_wr(`CR_COMMAND, {30'h0, rdop, 1'b1});
        r = 32'h0;
        n = 0;
        while (r[1] !== 1'b1 && n < 200)
        begin
            bus_rd(`CR_STATUS, r);
            n++;
        end
        check("done", {31'h0, r[1]}, 32'h1);
        bus_rd(`CR_RDATA, r);
        q = r[15:0];
    endtask : mgmt

    task dev_rd(input logic [4:0] ridx, input logic [15:0] exp, input string nm);
        logic [15:0] q;
        mgmt(1'b1, ridx, 16'h0000, q);
        check(nm, {16'h0, q}, {16'h0, exp});
    endtask : dev_rd

    task dev_wr(input logic [4:0] ridx, input logic [15:0] d);
        logic [15:0] q;
        mgmt(1'b0, ridx, d, q);
        check("wire", {5'h0, fsh[26:0]}, {5'h0, 1'b0, st, ridx, d});
    endtask : dev_wr

    task settle;
        repeat (3) @(posedge clock_in);
        @(negedge clock_in);
    endtask : settle

    // order: rx tx duplex speed polarity monitor interrupt
    task line(input logic [6:0] v);
        @(posedge clock_in);
        {rx, tx, fd, spd, pol, carrier_integrity_monitor, intr} <= v;
        settle();
    endtask : line

    task do_reset(input logic [4:0] a, input logic h, input logic f);
        @(posedge clock_in);
        {sta_s, hub_s, fib_s} <= {a, h, f};
        rst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        st = a;
        repeat (3) @(posedge clock_in);
    endtask : do_reset

    initial
    begin
        repeat (20000) @(posedge clock_in);
        error_cnt++;
        end_sim();
    end

    initial
    begin
        do_reset(5'h03, 1'b1, 1'b1);
        dev_rd(5'h19, 16'h0223, "ctrl_reset");
        dev_rd(5'h18, 16'h0080, "hb_hub");
        line(7'b0101010);
        check("cs_hub_tx", {31'h0, cs}, 32'h0);
        check("cim_hub", {31'h0, cime}, 32'h0);
        check("hb_hub_out", {31'h0, hbd}, 32'h1);
        check("fefi_fiber", {31'h0, fefo}, 32'h1);
        check("bps_fiber", {31'h0, bpso}, 32'h1);
        check("iso_strap", {31'h0, iso}, 32'h0);
        dev_wr(5'h19, 16'h0003);
        settle();
        check("cs_node_tx", {31'h0, cs}, 32'h1);
        check("hb_node", {31'h0, hbd}, 32'h0);
        check("fefi_copper", {31'h0, fefo}, 32'h0);
        @(posedge clock_in);
        {fefi, bps} <= 2'b10;
        settle();
        check("fefi_ext", {31'h0, fefo}, 32'h1);
        check("bps_ext", {31'h0, bpso}, 32'h0);
        @(posedge clock_in);
        {fefi, bps} <= 2'b01;
        settle();
        check("bps_pass", {31'h0, bpso}, 32'h1);
        dev_rd(5'h18, 16'h0000, "hb_node_rd");
        dev_wr(5'h18, 16'h0080);
        dev_rd(5'h18, 16'h0080, "hb_sw_rd");
        for (int m = 0; m < 4; m++)
        begin
            dev_wr(5'h19, {7'h0, m[1:0], 7'h03});
            line(7'b1000010);
            check("rx_led_a", {31'h0, rxl}, 32'h1);
            check("tx_led_a", {31'h0, txl}, {31'h0, 1'(4'b0110 >> m)});
            line(7'b0100001);
            check("rx_led_b", {31'h0, rxl}, {31'h0, 1'(4'b1100 >> m)});
            check("tx_led_b", {31'h0, txl}, {31'h0, 1'(4'b1001 >> m)});
        end
        dev_wr(5'h19, 16'h0043);
        line(7'b0000100);
        check("dup_pol_10", {31'h0, dupl}, 32'h1);
        line(7'b0001100);
        check("dup_pol_100", {31'h0, dupl}, 32'h0);
        line(7'b0011100);
        check("dup_fd_100", {31'h0, dupl}, 32'h1);
        check("hb_fd", {31'h0, hbd}, 32'h1);
        dev_wr(5'h19, 16'h0003);
        line(7'b0000100);
        check("dup_mode0", {31'h0, dupl}, 32'h0);
        dev_wr(5'h19, 16'h0000);
        st = 5'h00;
        settle();
        check("iso_written", {31'h0, iso}, 32'h0);
        dev_rd(5'h19, 16'h0000, "addr_zero");
        bus_rd(5'h14, s);
        check("unmapped", s, 32'h0);
        do_reset(5'h00, 1'b0, 1'b0);
        settle();
        check("iso_zero", {31'h0, iso}, 32'h1);
        dev_rd(5'h00, 16'h0400, "bmc_iso");
        dev_wr(5'h00, 16'h0000);
        settle();
        check("iso_clear", {31'h0, iso}, 32'h0);
        end_sim();
    end
endmodule : tb
